// >>> rtl/jfl_device.sv
// Device end: command interpreter, fuse and lock store, page scan chains
`timescale 1ns/1ns
`default_nettype none
`include "jfl_defs.svh"
module jfl_device #(
    parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'hA5, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C  // Arbitrary identity value
) (
    input wire logic mclk, // System clock
    input wire logic reset_n, // Asynchronous reset
    jfl_link_if.dev link, // Test-port pins
    output logic [7:0] fuse_ext, // Extended fuse byte
    output logic [7:0] fuse_high, // High fuse byte
    output logic [7:0] fuse_low, // Low fuse byte
    output logic [5:0] lock_bits, // Lock bits
    output logic nvm_busy, // Fuse or lock write in progress
    input wire logic [7:0] cal_byte, // Calibration value
    output logic [15:0] ee_addr, // EEPROM read address
    input wire logic [7:0] ee_rdata, // EEPROM byte at ee_addr
    output logic [15:0] page_addr, // Flash page address
    output logic pg_wr, // Page buffer byte write pulse
    output logic [7:0] pg_wr_idx, // Byte index of pg_wr
    output logic [7:0] pg_wdata, // Byte written
    output logic [7:0] pg_rd_idx, // Byte index to read
    input wire logic [7:0] pg_rdata // Page byte at pg_rd_idx
);
    logic tck_s1, tck_s2, tck_s3;
    logic tms_s1, tms_s2;
    logic tdi_s1, tdi_s2;
    jfl_pkg::jfl_chain_t chain_s1, chain_s2;
    jfl_pkg::jfl_tap_t tap;
    logic [14:0] csh;
    logic [14:0] resp;
    logic [7:0] mode;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data;
    logic [7:0] psh;
    logic [2:0] bitc;
    logic [7:0] idx;
    logic [15:0] wcnt;
    logic rise;
    logic rise_q;
    logic upd;
    logic [6:0] op;
    logic [7:0] lo;
    logic go_ext, go_high, go_low, go_lock, go_any;
    logic [7:0] rd_byte;

    function automatic logic [15:0] keep_low(input logic [15:0] a, input logic [4:0] top);
        logic [15:0] m;
        m = 16'hFFFF >> (5'h0F - top);
        return a & m;
    endfunction

    function automatic jfl_pkg::jfl_tap_t tap_next(input jfl_pkg::jfl_tap_t s, input logic t);
        unique case (s)
            jfl_pkg::TAP_RESET: tap_next = t ? jfl_pkg::TAP_RESET : jfl_pkg::TAP_IDLE;
            jfl_pkg::TAP_IDLE: tap_next = t ? jfl_pkg::TAP_SEL_DR : jfl_pkg::TAP_IDLE;
            jfl_pkg::TAP_SEL_DR: tap_next = t ? jfl_pkg::TAP_SEL_IR : jfl_pkg::TAP_CAPTURE;
            jfl_pkg::TAP_CAPTURE: tap_next = t ? jfl_pkg::TAP_EXIT1 : jfl_pkg::TAP_SHIFT;
            jfl_pkg::TAP_SHIFT: tap_next = t ? jfl_pkg::TAP_EXIT1 : jfl_pkg::TAP_SHIFT;
            jfl_pkg::TAP_EXIT1: tap_next = t ? jfl_pkg::TAP_UPDATE : jfl_pkg::TAP_PAUSE;
            jfl_pkg::TAP_PAUSE: tap_next = t ? jfl_pkg::TAP_EXIT2 : jfl_pkg::TAP_PAUSE;
            jfl_pkg::TAP_EXIT2: tap_next = t ? jfl_pkg::TAP_UPDATE : jfl_pkg::TAP_SHIFT;
            jfl_pkg::TAP_UPDATE: tap_next = t ? jfl_pkg::TAP_SEL_DR : jfl_pkg::TAP_IDLE;
            // Instruction path is not used here; chain is picked by the chain pins
            jfl_pkg::TAP_SEL_IR: tap_next = t ? jfl_pkg::TAP_RESET : jfl_pkg::TAP_IDLE;
            default: tap_next = jfl_pkg::TAP_RESET;
        endcase
    endfunction

    // Every pin passes two flops; tck gets a third for edge finding
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b0;
            tdi_s2 <= 1'b0;
            chain_s1 <= jfl_pkg::CHAIN_CMD;
            chain_s2 <= jfl_pkg::CHAIN_CMD;
        end else begin
            tck_s1 <= link.tck;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= link.tms;
            tms_s2 <= tms_s1;
            tdi_s1 <= link.tdi;
            tdi_s2 <= tdi_s1;
            chain_s1 <= link.chain;
            chain_s2 <= chain_s1;
        end
    end

    assign rise = tck_s2 & ~tck_s3;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tap <= jfl_pkg::TAP_RESET;
        end else if (rise) begin
            tap <= tap_next(tap, tms_s2);
        end
    end

    // Command chain: result goes out while the next word comes in
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            csh <= 15'h0000;
        end else if (rise && chain_s2 == jfl_pkg::CHAIN_CMD) begin
            if (tap == jfl_pkg::TAP_CAPTURE) begin
                csh <= resp;
            end else if (tap == jfl_pkg::TAP_SHIFT) begin
                csh <= {tdi_s2, csh[14:1]};
            end
        end
    end

    assign upd = rise && tap == jfl_pkg::TAP_UPDATE && chain_s2 == jfl_pkg::CHAIN_CMD;
    assign op = csh[14:8];
    assign lo = csh[7:0];
    // Writes start on the strobe whose bit 9 has dropped; a second start while busy is ignored
    assign go_ext = upd && mode == `JFL_MODE_FUSE_WR && op == `JFL_OP_EXT_GO && !nvm_busy;
    assign go_high = upd && mode == `JFL_MODE_FUSE_WR && op == `JFL_OP_HIGH_GO && !nvm_busy;
    assign go_low = upd && mode == `JFL_MODE_FUSE_WR && op == `JFL_OP_LOW_GO && !nvm_busy;
    assign go_lock = upd && mode == `JFL_MODE_LOCK_WR && op == `JFL_OP_LOW_GO && !nvm_busy;
    assign go_any = go_ext | go_high | go_low | go_lock;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= `JFL_MODE_NOP;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            data <= 8'hFF;
        end else if (upd) begin
            if (op == `JFL_OP_ENTER) begin
                mode <= lo;
            end
            if (op == `JFL_OP_ADDR_LO) begin
                addr_lo <= lo;
            end
            if (op == `JFL_OP_ADDR_HI) begin
                addr_hi <= lo;
            end
            if (op == `JFL_OP_DATA) begin
                data <= lo;
            end
        end
    end

    // Values commit at the start of the write; busy models the write time
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_ext <= `JFL_FUSE_EXT_RST;
            fuse_high <= `JFL_FUSE_HIGH_RST;
            fuse_low <= `JFL_FUSE_LOW_RST;
            lock_bits <= `JFL_LOCK_RST;
        end else begin
            if (go_ext) begin
                fuse_ext <= data;
            end
            if (go_high) begin
                fuse_high <= data;
            end
            if (go_low) begin
                fuse_low <= data;
            end
            if (go_lock) begin
                lock_bits <= lock_bits & data[5:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wcnt <= 16'h0000;
            nvm_busy <= 1'b0;
        end else if (go_any) begin
            wcnt <= 16'(`JFL_WRITE_CYC);
            nvm_busy <= 1'b1;
        end else if (wcnt != 16'h0000) begin
            wcnt <= wcnt - 16'h0001;
            nvm_busy <= wcnt != 16'h0001;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (mode == `JFL_MODE_FUSE_RD) begin
            unique case (op[6:1])
                6'(`JFL_OP_EXT_RD >> 1): rd_byte = fuse_ext;
                6'(`JFL_OP_HIGH_RD >> 1): rd_byte = fuse_high;
                6'(`JFL_OP_LOW_RD >> 1): rd_byte = fuse_low;
                6'(`JFL_OP_LOCK_RD >> 1): rd_byte = {`JFL_LOCK_PAD, lock_bits};
                default: rd_byte = 8'h00;
            endcase
        end else if (mode == `JFL_MODE_SIG_RD && op == `JFL_OP_LOW_RD) begin
            unique case (addr_lo[1:0])
                2'h0: rd_byte = SIG_BYTE0;
                2'h1: rd_byte = SIG_BYTE1;
                2'h2: rd_byte = SIG_BYTE2;
                2'h3: rd_byte = 8'hFF;
            endcase
        end else if (mode == `JFL_MODE_SIG_RD && op == `JFL_OP_LOCK_RD) begin
            rd_byte = cal_byte;
        end else if (mode == `JFL_MODE_EE_RD && op == `JFL_OP_LOW_RD) begin
            rd_byte = ee_rdata;
        end
    end

    // Reply for the next scan: completion flag plus any read byte
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resp <= 15'h0000;
        end else if (upd) begin
            resp <= 15'h0000;
            resp[`JFL_DONE_BIT] <= !(nvm_busy | go_any);
            resp[7:0] <= rd_byte;
        end else if (!nvm_busy) begin
            resp[`JFL_DONE_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ee_addr <= 16'h0000;
            page_addr <= 16'h0000;
        end else begin
            ee_addr <= keep_low({addr_hi, addr_lo}, `JFL_EEPROM_ADDR_TOP_BIT);
            page_addr <= keep_low({addr_hi, addr_lo}, `JFL_PROGRAM_ADDR_TOP_BIT);
        end
    end

    // Page chains share one 8-bit shifter; a byte moves every eighth shift
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            psh <= 8'h00;
            bitc <= 3'h0;
            idx <= 8'h00;
            pg_wr <= 1'b0;
            pg_wr_idx <= 8'h00;
            pg_wdata <= 8'h00;
            pg_rd_idx <= 8'h00;
        end else begin
            pg_wr <= 1'b0;
            if (rise && chain_s2 != jfl_pkg::CHAIN_CMD) begin
                if (tap == jfl_pkg::TAP_CAPTURE) begin
                    bitc <= 3'h0;
                    idx <= 8'h00;
                    pg_rd_idx <= 8'h00;
                end else if (tap == jfl_pkg::TAP_SHIFT) begin
                    bitc <= bitc + 3'h1;
                    if (chain_s2 == jfl_pkg::CHAIN_LOAD) begin
                        psh <= {tdi_s2, psh[7:1]};
                        if (bitc == 3'h7) begin
                            pg_wr <= 1'b1;
                            pg_wr_idx <= idx;
                            pg_wdata <= {tdi_s2, psh[7:1]};
                            idx <= idx + 8'h01;
                        end
                    end else if (bitc == 3'h7) begin
                        // First eight shifts only fetch byte 0; their output is junk
                        psh <= pg_rdata;
                        idx <= idx + 8'h01;
                        pg_rd_idx <= idx + 8'h01;
                    end else begin
                        psh <= {1'b0, psh[7:1]};
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rise_q <= 1'b0;
            link.tdo <= 1'b0;
        end else begin
            // Output moves only just after a seen rise, so a chain switch cannot glitch it
            rise_q <= rise;
            if (rise_q) begin
                link.tdo <= chain_s2 == jfl_pkg::CHAIN_CMD ? csh[0] : psh[0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/jfl_defs.svh
// Constants for the fuse, lock and page programming link
`ifndef JFL_DEFS_SVH
`define JFL_DEFS_SVH

`define JFL_CMD_W 15
`define JFL_DONE_BIT 9
// Upper seven bits of a command word
`define JFL_OP_ENTER 7'h23
`define JFL_OP_ADDR_LO 7'h03
`define JFL_OP_ADDR_HI 7'h07
`define JFL_OP_DATA 7'h13
`define JFL_OP_EXT_RD 7'h3A
`define JFL_OP_EXT_IDLE 7'h3B
`define JFL_OP_EXT_GO 7'h39
`define JFL_OP_HIGH_RD 7'h3E
`define JFL_OP_HIGH_IDLE 7'h37
`define JFL_OP_HIGH_GO 7'h35
`define JFL_OP_LOW_RD 7'h32
`define JFL_OP_LOW_IDLE 7'h33
`define JFL_OP_LOW_GO 7'h31
`define JFL_OP_LOCK_RD 7'h36
// Mode bytes carried by the enter command
`define JFL_MODE_NOP 8'h00
`define JFL_MODE_FUSE_WR 8'h40
`define JFL_MODE_LOCK_WR 8'h20
`define JFL_MODE_FUSE_RD 8'h04
`define JFL_MODE_SIG_RD 8'h08
`define JFL_MODE_EE_RD 8'h03
// Reset values of the stored bytes, one means unprogrammed
`define JFL_FUSE_EXT_RST 8'hFF
`define JFL_FUSE_HIGH_RST 8'hFF
`define JFL_FUSE_LOW_RST 8'hFF
`define JFL_LOCK_RST 6'h3F
`define JFL_LOCK_PAD 2'h3
// Address widths and page size
`define JFL_PROGRAM_ADDR_TOP_BIT 5'h0F
`define JFL_EEPROM_ADDR_TOP_BIT 5'h0B
`define JFL_PAGE_BYTES 256
// Timing
`define JFL_MCLK_NS 100
`define JFL_WRITE_TIME_US 10
`define JFL_WRITE_CYC ((`JFL_WRITE_TIME_US * 1000) / `JFL_MCLK_NS)
`define JFL_TCK_PERIOD_NS 800
`define JFL_TCK_HALF_CYC (`JFL_TCK_PERIOD_NS / (2 * `JFL_MCLK_NS))
`define JFL_RESET_WALK 5

`endif

// >>> rtl/jfl_pkg.sv
// Types shared by both ends of the programming link
package jfl_pkg;
    typedef enum logic [1:0] {
        CHAIN_CMD = 2'h0,
        CHAIN_LOAD = 2'h1,
        CHAIN_READ = 2'h2
    } jfl_chain_t;

    typedef enum logic [9:0] {
        TAP_RESET = 10'h001,
        TAP_IDLE = 10'h002,
        TAP_SEL_DR = 10'h004,
        TAP_CAPTURE = 10'h008,
        TAP_SHIFT = 10'h010,
        TAP_EXIT1 = 10'h020,
        TAP_PAUSE = 10'h040,
        TAP_EXIT2 = 10'h080,
        TAP_UPDATE = 10'h100,
        TAP_SEL_IR = 10'h200
    } jfl_tap_t;

    typedef enum logic [7:0] {
        PH_RESET = 8'h01,
        PH_IDLE = 8'h02,
        PH_SEL = 8'h04,
        PH_CAP = 8'h08,
        PH_ENTER = 8'h10,
        PH_BITS = 8'h20,
        PH_UPD = 8'h40,
        PH_FIN = 8'h80
    } jfl_phase_t;
endpackage

// >>> rtl/jfl_link_if.sv
// Serial test-port pins between programmer and device
`timescale 1ns/1ns
`default_nettype none
interface jfl_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    jfl_pkg::jfl_chain_t chain;

    modport prog (output tck, output tms, output tdi, output chain, input tdo);
    modport dev (input tck, input tms, input tdi, input chain, output tdo);
endinterface
`default_nettype wire

// >>> rtl/jfl_programmer.sv
// Programmer end: makes the test clock and runs one data-register scan per request
`timescale 1ns/1ns
`default_nettype none
`include "jfl_defs.svh"
module jfl_programmer (
    input wire logic mclk, // System clock
    input wire logic reset_n, // Asynchronous reset
    jfl_link_if.prog link, // Test-port pins
    input wire logic start, // Begin a scan
    input wire jfl_pkg::jfl_chain_t chain_sel, // Chain to scan
    input wire logic [14:0] cmd_word, // Command for the command chain
    input wire logic [11:0] bit_len, // Shift length in bits
    input wire logic [7:0] in_byte, // Next byte for the page load chain
    output logic byte_take, // in_byte consumed
    output logic [7:0] out_byte, // Byte collected from tdo
    output logic byte_done, // out_byte valid pulse
    output logic [14:0] resp, // Command chain reply
    output logic done, // Scan finished pulse
    output logic ready // Idle, start accepted
);
    jfl_pkg::jfl_phase_t ph;
    logic [2:0] div;
    logic [11:0] left;
    logic [2:0] walk;
    logic [14:0] tx;
    logic [14:0] rx;
    logic [2:0] bcnt;
    logic tdo_s1, tdo_s2;
    logic tick, rising, falling;

    assign tick = div == 3'(`JFL_TCK_HALF_CYC - 1);
    assign rising = tick && !link.tck && ph != jfl_pkg::PH_IDLE;
    assign falling = tick && link.tck;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tdo_s1 <= 1'b0;
            tdo_s2 <= 1'b0;
        end else begin
            tdo_s1 <= link.tdo;
            tdo_s2 <= tdo_s1;
        end
    end

    // The test clock only runs while a walk or a scan is in progress
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div <= 3'h0;
            link.tck <= 1'b0;
        end else begin
            div <= tick ? 3'h0 : div + 3'h1;
            if (rising || falling) begin
                link.tck <= !link.tck;
            end
        end
    end

    // Pins change on the falling edge so they are settled at the next rise
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            link.tms <= 1'b1;
            link.tdi <= 1'b0;
            link.chain <= jfl_pkg::CHAIN_CMD;
        end else begin
            if (ready && start) begin
                link.chain <= chain_sel;
                // tck is low here, and the first rise of a scan must see tms high
                link.tms <= 1'b1;
            end
            if (falling) begin
                link.tms <= ph == jfl_pkg::PH_RESET || ph == jfl_pkg::PH_SEL ||
                            ph == jfl_pkg::PH_UPD || (ph == jfl_pkg::PH_BITS && left == 12'h001);
                link.tdi <= ph == jfl_pkg::PH_BITS && tx[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ph <= jfl_pkg::PH_RESET;
            walk <= 3'h0;
            left <= 12'h000;
            tx <= 15'h0000;
            rx <= 15'h0000;
            bcnt <= 3'h0;
            byte_take <= 1'b0;
            byte_done <= 1'b0;
            out_byte <= 8'h00;
            resp <= 15'h0000;
            done <= 1'b0;
            ready <= 1'b0;
        end else begin
            byte_take <= 1'b0;
            byte_done <= 1'b0;
            done <= 1'b0;
            if (ready && start) begin
                ph <= jfl_pkg::PH_SEL;
                ready <= 1'b0;
                left <= bit_len;
                bcnt <= 3'h0;
                tx <= chain_sel == jfl_pkg::CHAIN_LOAD ? {7'h00, in_byte} : cmd_word;
                byte_take <= chain_sel == jfl_pkg::CHAIN_LOAD;
            end else if (falling && ph == jfl_pkg::PH_IDLE) begin
                // Ready waits for the fall so chain and tms never move while tck is high
                ready <= 1'b1;
            end else if (rising) begin
                unique case (ph)
                    jfl_pkg::PH_RESET: begin
                        if (walk == 3'(`JFL_RESET_WALK)) begin
                            ph <= jfl_pkg::PH_FIN;
                        end else begin
                            walk <= walk + 3'h1;
                        end
                    end
                    jfl_pkg::PH_SEL: ph <= jfl_pkg::PH_CAP;
                    jfl_pkg::PH_CAP: ph <= jfl_pkg::PH_ENTER;
                    jfl_pkg::PH_ENTER: ph <= jfl_pkg::PH_BITS;
                    jfl_pkg::PH_BITS: begin
                        rx <= {tdo_s2, rx[14:1]};
                        tx <= {1'b0, tx[14:1]};
                        bcnt <= bcnt + 3'h1;
                        left <= left - 12'h001;
                        if (bcnt == 3'h7 && link.chain != jfl_pkg::CHAIN_CMD) begin
                            out_byte <= {tdo_s2, rx[14:8]};
                            byte_done <= 1'b1;
                            if (link.chain == jfl_pkg::CHAIN_LOAD) begin
                                tx <= {7'h00, in_byte};
                                byte_take <= 1'b1;
                            end
                        end
                        if (left == 12'h001) begin
                            ph <= jfl_pkg::PH_UPD;
                        end
                    end
                    jfl_pkg::PH_UPD: ph <= jfl_pkg::PH_FIN;
                    jfl_pkg::PH_FIN: begin
                        ph <= jfl_pkg::PH_IDLE;
                        // The reset walk ends here too but is not a scan
                        walk <= 3'(`JFL_RESET_WALK + 1);
                        done <= walk == 3'(`JFL_RESET_WALK + 1);
                        resp <= rx;
                    end
                    default: ph <= jfl_pkg::PH_RESET;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/jfl_link_properties.sv
// Checker on the test-port pins between the two ends
`timescale 1ns/1ns
`default_nettype none
module jfl_link_properties (
    input wire logic mclk, // System clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic tck, // Test clock
    input wire logic tms, // Mode select
    input wire logic tdi, // Data to device
    input wire logic tdo, // Data to programmer
    input wire jfl_pkg::jfl_chain_t chain // Chain select
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // Test clock half period is four system clocks
    property p_tck_high; $rose(tck) |=> tck [*3] ##1 !tck; endproperty
    a_tck_high: assert property (p_tck_high) else $error("tck high phase wrong");
    property p_tck_low; $fell(tck) |=> !tck [*3]; endproperty
    a_tck_low: assert property (p_tck_low) else $error("tck low phase short");
    property p_tms_hold; tck && $past(tck) |-> $stable(tms); endproperty
    a_tms_hold: assert property (p_tms_hold) else $error("tms moved while tck high");
    property p_tdi_hold; tck && $past(tck) |-> $stable(tdi); endproperty
    a_tdi_hold: assert property (p_tdi_hold) else $error("tdi moved while tck high");
    property p_chain_hold; $rose(tck) |=> $stable(chain) [*3]; endproperty
    a_chain_hold: assert property (p_chain_hold) else $error("chain moved");
    // Device may only move tdo after it has seen a rise, so a low phase is quiet
    property p_tdo_hold; !tck && !$past(tck) |-> $stable(tdo); endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved while tck low");
    property p_reset_idle; $rose(reset_n) |-> !tck && tms; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle");
    property p_walk_start; $rose(reset_n) |-> ##[1:40] $rose(tck); endproperty
    a_walk_start: assert property (p_walk_start) else $error("reset walk missing");
    c_load: cover property ($rose(tck) && chain == jfl_pkg::CHAIN_LOAD);
    c_read: cover property ($rose(tck) && chain == jfl_pkg::CHAIN_READ);
    c_tdo: cover property ($rose(tdo));
endmodule
`default_nettype wire

// >>> testbench/jfl_fuse_lock_page_programming_tb.sv
// Bench joining programmer and device ends over the link
`timescale 1ns/1ns
`default_nettype none
module jfl_fuse_lock_page_programming_tb;
    // Row is check kind, expected byte, command; kind 1 byte, 2 busy, 3 idle
    // The 3500 strobe follows a 13C1 row, so its leading 3700 command is left out
    localparam int NR = 44;
    localparam logic [27:0] ROWS [NR] = '{
        28'h000_2340, 28'h000_13A5, 28'h000_3B00, 28'h000_3900, 28'h200_3B00,
        28'h000_3B00, 28'h000_3700, 28'h300_3700, 28'h000_13C1, 28'h000_3500,
        28'h200_3700, 28'h300_3700, 28'h000_1318, 28'h000_3300, 28'h000_3100,
        28'h200_3300, 28'h300_3300, 28'h000_2320, 28'h000_13E6,
        28'h000_3300, 28'h000_3100, 28'h200_3300, 28'h000_3300, 28'h300_3300,
        28'h000_2304, 28'h000_3A00, 28'h1A5_3E00, 28'h1C1_3200, 28'h118_3700,
        28'h1E6_2308, 28'h000_0301, 28'h000_3200, 28'h1A5_3600, 28'h1C3_2303,
        28'h000_07FF, 28'h000_0334, 28'h000_3200, 28'h16E_2300, 28'h000_3300,
        28'h000_3100, 28'h300_3300, 28'h000_2304, 28'h000_3A00, 28'h1FF_3B00};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    jfl_pkg::jfl_chain_t chain_sel = jfl_pkg::CHAIN_CMD;
    logic [14:0] cmd_word = 15'h0000;
    logic [11:0] bit_len = 12'h00F;
    logic [7:0] in_byte = 8'h00;
    logic [7:0] cal_byte = 8'hC3;
    logic byte_take, byte_done, done, ready, nvm_busy, pg_wr;
    logic [7:0] out_byte, fuse_ext, fuse_high, fuse_low, pg_wr_idx, pg_wdata, pg_rd_idx;
    logic [14:0] resp;
    logic [5:0] lock_bits;
    logic [15:0] ee_addr, page_addr;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int nwr = 0;
    int nrd = 0;
    jfl_link_if jfl_link_if_inst ();
    jfl_programmer jfl_programmer_inst (.mclk(mclk), .reset_n(reset_n),
        .link(jfl_link_if_inst), .start(start), .chain_sel(chain_sel), .cmd_word(cmd_word),
        .bit_len(bit_len), .in_byte(in_byte), .byte_take(byte_take), .out_byte(out_byte),
        .byte_done(byte_done), .resp(resp), .done(done), .ready(ready));
    // Memories are modelled as plain functions of the index
    jfl_device jfl_device_inst (.mclk(mclk), .reset_n(reset_n), .link(jfl_link_if_inst),
        .fuse_ext(fuse_ext), .fuse_high(fuse_high), .fuse_low(fuse_low),
        .lock_bits(lock_bits), .nvm_busy(nvm_busy), .cal_byte(cal_byte),
        .ee_addr(ee_addr), .ee_rdata(ee_addr[7:0] ^ 8'h5A), .page_addr(page_addr),
        .pg_wr(pg_wr), .pg_wr_idx(pg_wr_idx), .pg_wdata(pg_wdata), .pg_rd_idx(pg_rd_idx),
        .pg_rdata(~pg_rd_idx));
    jfl_link_properties jfl_link_properties_inst (.mclk(mclk), .reset_n(reset_n),
        .tck(jfl_link_if_inst.tck), .tms(jfl_link_if_inst.tms), .tdi(jfl_link_if_inst.tdi),
        .tdo(jfl_link_if_inst.tdo), .chain(jfl_link_if_inst.chain));
    initial begin
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic scan(input jfl_pkg::jfl_chain_t ch, input logic [14:0] c,
                        input logic [11:0] n);
        while (ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        chain_sel <= ch;
        cmd_word <= c;
        bit_len <= n;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        @(negedge mclk);
        while (done !== 1'b1) @(negedge mclk);
    endtask
    // A reply belongs to the previous command, so each row checks its predecessor
    task automatic run_rows(input int first, input int last);
        logic [27:0] r;
        for (int i = first; i <= last; i++) begin
            r = ROWS[i];
            scan(jfl_pkg::CHAIN_CMD, r[14:0], 12'h00F);
            case (r[27:24])
                4'h1: chk({8'h00, resp[7:0]}, {8'h00, r[23:16]});
                4'h2: chk({15'h0000, resp[9]}, 16'h0000);
                4'h3: chk({15'h0000, resp[9]}, 16'h0001);
                default: ;
            endcase
        end
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            $display("ERROR %0t: run timed out", $time);
            tally_and_finish();
        end
        if (byte_take === 1'b1) begin
            in_byte <= in_byte + 8'h01;
        end
        if (pg_wr === 1'b1) begin
            chk({pg_wr_idx, pg_wdata}, {8'(nwr), 8'(nwr)});
            nwr++;
        end
        if (byte_done === 1'b1 && chain_sel == jfl_pkg::CHAIN_READ) begin
            if (nrd > 0) begin
                chk({8'h00, out_byte}, {8'h00, ~8'(nrd - 1)});
            end
            nrd++;
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        run_rows(0, NR - 4);
        $display("test command rows done");
        scan(jfl_pkg::CHAIN_LOAD, 15'h0000, 12'h800);
        chk(16'(nwr), 16'h0100);
        scan(jfl_pkg::CHAIN_READ, 15'h0000, 12'h808);
        chk(16'(nrd), 16'h0101);
        $display("test page chains done");
        chk({8'h00, fuse_ext}, 16'h00A5);
        chk({10'h000, lock_bits}, 16'h0026);
        chk({fuse_high, fuse_low}, 16'hC118);
        chk(ee_addr, 16'h0F34);
        chk(page_addr, 16'hFF34);
        $display("test stored values done");
        @(posedge mclk);
        reset_n <= 1'b0;
        @(negedge mclk);
        chk({1'b0, nvm_busy, lock_bits, fuse_ext}, 16'h3FFF);
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        run_rows(NR - 3, NR - 1);
        $display("test reset recovery done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
